// ==== core/csr_pkg.sv ====
package csr_pkg;
	localparam logic [7:0] CSR_ADDR_BUCK3    = 8'h18;
	localparam logic [7:0] CSR_ADDR_BBOOST   = 8'h19;
	localparam logic [7:0] CSR_RST_BUCK3     = 8'h8C;
	localparam logic [7:0] CSR_RST_BBOOST    = 8'hB2;
	localparam logic [7:0] CSR_ALT_BUCK3     = 8'h8C;
	localparam logic [7:0] CSR_ALT_BBOOST    = 8'hB2;
	localparam int         CSR_PSE_BIT       = 7;
	localparam int         CSR_RSV_BIT       = 6;
	localparam logic [7:0] CSR_WR_MASK       = 8'hBF;
	localparam logic [5:0] CSR_BB_CODE_MAX   = 6'h34;
	localparam int         CSR_CLK_MHZ       = 125;
	localparam int         CSR_BLANK_MS      = 5;
	localparam int         CSR_BLANK_CYCLES  = CSR_BLANK_MS * 1000 * CSR_CLK_MHZ;
	localparam int         CSR_CNT_W         = 20;

	typedef struct packed {
		logic       wrEn;
		logic [7:0] addr;
		logic [7:0] data;
	} csr_wr_t;

	typedef struct packed {
		logic       pulseSkipEnable;
		logic [5:0] voltageCode;
	} csr_setpoint_t;

	typedef enum logic [1:0] {
		CSR_ST_INIT  = 2'b00,
		CSR_ST_RUN   = 2'b01
	} csr_state_t;
endpackage

// ==== core/csr_blank_timer.sv ====
`timescale 1ns/1ps
module csr_blank_timer
	import csr_pkg::*;
#(
	parameter int BLANK_CYCLES = CSR_BLANK_CYCLES
)
(
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic start,
	output logic      blank
);
	logic [CSR_CNT_W-1:0] cnt_reg;
	logic [CSR_CNT_W-1:0] cnt_next;
	logic                 blank_reg;
	logic                 blank_next;

	always_comb
	begin
		cnt_next   = cnt_reg;
		blank_next = blank_reg;
		if (start)
		begin
			cnt_next   = CSR_CNT_W'(BLANK_CYCLES - 1);
			blank_next = 1'b1;
		end
		else if (cnt_reg != '0)
			cnt_next = cnt_reg - 1'b1;
		else
			blank_next = 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			cnt_reg   <= '0;
			blank_reg <= 1'b0;
		end
		else
		begin
			cnt_reg   <= cnt_next;
			blank_reg <= blank_next;
		end
	end

	assign blank = blank_reg;
endmodule

// ==== core/csr_setpoint_regs.sv ====
`timescale 1ns/1ps
module csr_setpoint_regs
	import csr_pkg::*;
#(
	parameter int BLANK_CYCLES = CSR_BLANK_CYCLES
)
(
	input  wire logic          mclk,
	input  wire logic          rst_n,
	input  wire csr_wr_t       wrReq,
	input  wire logic [7:0]    rdAddr,
	input  wire logic          unlocked,
	input  wire logic          defaultSelectResistor,
	output logic [7:0]         rdData,
	output logic               rdHit,
	output csr_setpoint_t      buck3Set,
	output csr_setpoint_t      bboostSet,
	output logic               buck3Blank,
	output logic               bboostBlank
);
	csr_state_t state_reg;
	csr_state_t state_next;
	logic [7:0] buck3_reg;
	logic [7:0] buck3_next;
	logic [7:0] bboost_reg;
	logic [7:0] bboost_next;
	logic [7:0] rdData_reg;
	logic [7:0] rdData_next;
	logic       rdHit_reg;
	logic       rdHit_next;
	logic       wrBuck3;
	logic       wrBboost;
	logic       b3BlankW;
	logic       bbBlankW;

	function automatic logic [7:0] clean(input logic [7:0] v);
		clean = v & CSR_WR_MASK;
	endfunction

	// protected writes only when unlocked
	assign wrBuck3  = wrReq.wrEn && unlocked && (wrReq.addr == CSR_ADDR_BUCK3);
	assign wrBboost = wrReq.wrEn && unlocked && (wrReq.addr == CSR_ADDR_BBOOST);

	always_comb
	begin
		state_next  = state_reg;
		buck3_next  = buck3_reg;
		bboost_next = bboost_reg;
		case (state_reg)
			CSR_ST_INIT:
			begin
				// strap sampled after reset release
				buck3_next  = defaultSelectResistor ? CSR_ALT_BUCK3 : CSR_RST_BUCK3;
				bboost_next = defaultSelectResistor ? CSR_ALT_BBOOST : CSR_RST_BBOOST;
				state_next  = CSR_ST_RUN;
			end
			CSR_ST_RUN:
			begin
				// codes update directly, no slew or go gating
				if (wrBuck3)
					buck3_next = clean(wrReq.data);
				if (wrBboost)
					bboost_next = clean(wrReq.data);
			end
			default:
				state_next = CSR_ST_INIT;
		endcase
	end

	always_comb
	begin
		rdData_next = 8'h00;
		rdHit_next  = 1'b1;
		case (rdAddr)
			CSR_ADDR_BUCK3:  rdData_next = clean(buck3_reg);
			CSR_ADDR_BBOOST: rdData_next = clean(bboost_reg);
			default:         rdHit_next  = 1'b0;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			state_reg  <= CSR_ST_INIT;
			buck3_reg  <= CSR_RST_BUCK3;
			bboost_reg <= CSR_RST_BBOOST;
			rdData_reg <= 8'h00;
			rdHit_reg  <= 1'b0;
		end
		else
		begin
			state_reg  <= state_next;
			buck3_reg  <= buck3_next;
			bboost_reg <= bboost_next;
			rdData_reg <= rdData_next;
			rdHit_reg  <= rdHit_next;
		end
	end

	// one blanking window per converter
	csr_blank_timer #(.BLANK_CYCLES(BLANK_CYCLES)) u_b3
	(
		.mclk  (mclk),
		.rst_n (rst_n),
		.start (wrBuck3 && (state_reg == CSR_ST_RUN)),
		.blank (b3BlankW)
	);

	csr_blank_timer #(.BLANK_CYCLES(BLANK_CYCLES)) u_bb
	(
		.mclk  (mclk),
		.rst_n (rst_n),
		.start (wrBboost && (state_reg == CSR_ST_RUN)),
		.blank (bbBlankW)
	);

	assign rdData      = rdData_reg;
	assign rdHit       = rdHit_reg;
	assign buck3Set    = '{pulseSkipEnable: buck3_reg[CSR_PSE_BIT], voltageCode: buck3_reg[5:0]};
	assign bboostSet   = '{pulseSkipEnable: bboost_reg[CSR_PSE_BIT], voltageCode: bboost_reg[5:0]};
	assign buck3Blank  = b3BlankW;
	assign bboostBlank = bbBlankW;
endmodule

// ==== sim/csr_setpoint_regs_chk.sv ====
`timescale 1ns/1ps
module csr_setpoint_regs_chk
	import csr_pkg::*;
(
	input logic		mclk,
	input logic		rst_n,
	input csr_wr_t		wrReq,
	input logic		unlocked,
	input logic [7:0]	rdData,
	input csr_setpoint_t	buck3Set,
	input csr_setpoint_t	bboostSet,
	input logic		buck3Blank,
	input logic		bboostBlank
);
	logic		upReg;
	wire		w3 = wrReq.wrEn & unlocked & upReg & wrReq.addr == 8'h18;
	wire		wb = wrReq.wrEn & unlocked & upReg & wrReq.addr == 8'h19;
	wire [6:0]	wd = {wrReq.data[7], wrReq.data[5:0]};
	always_ff @(posedge mclk) upReg <= rst_n;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	chk_b3_wr: assert property (w3 |=> buck3Set == $past(wd)) else $error("b3 set");
	chk_bb_wr: assert property (wb |=> bboostSet == $past(wd)) else $error("bb set");
	chk_b3_only: assert property (w3 |=> $stable(bboostSet)) else $error("bb moved");
	chk_set_hold: assert property (!w3 && !wb && upReg |=> $stable({buck3Set, bboostSet}))
		else $error("held");
	chk_b3_blk: assert property (w3 |=> buck3Blank[*8]) else $error("b3 blank");
	chk_bb_blk: assert property (wb |=> bboostBlank[*8]) else $error("bb blank");
	chk_b3_src: assert property ($rose(buck3Blank) |-> $past(w3)) else $error("b3 src");
	chk_bb_src: assert property ($rose(bboostBlank) |-> $past(wb)) else $error("bb src");
	chk_rsv_zero: assert property (rdData[CSR_RSV_BIT] == 1'b0) else $error("rsv bit");
endmodule
bind csr_setpoint_regs csr_setpoint_regs_chk i_chk (.*);

// ==== sim/csr_host_model.sv ====
`timescale 1ns/1ps
module csr_host_model
	import csr_pkg::*;
(
	input logic		mclk,
	output csr_wr_t		wrReq = '0,
	output logic		unlocked = 1'b0
);
	task wr(input logic [15:0] ad, input logic u);
		@(negedge mclk);
		unlocked <= u;
		wrReq <= {1'b1, ad};
		@(negedge mclk);
		wrReq.wrEn <= 1'b0;
	endtask
endmodule

// ==== sim/tb_csr_setpoint_regs.sv ====
`timescale 1ns/1ps
module tb_csr_setpoint_regs;
	import csr_pkg::*;
	logic		mclk = 1'b0;
	logic		rst_n = 1'b0;
	logic [7:0]	rdAddr = 8'h00;
	logic [7:0]	rdData;
	logic		unlocked;
	logic		rdHit;
	logic		strap = 1'b0;
	logic		b3Blank;
	logic		bbBlank;
	csr_setpoint_t	b3Set;
	csr_setpoint_t	bbSet;
	csr_wr_t	wrReq;
	int		errors = 0;
	int		checks = 0;
	logic [32:0]	rows [7] = '{33'h10000188C, 33'h1000019B2, 33'h118FF18BF,
		33'h119741934, 33'h0180018BF, 33'h118401800, 33'h11A551A00};
	always #4 mclk = ~mclk;
	csr_host_model i_csr_host_model (.mclk, .wrReq, .unlocked);
	csr_setpoint_regs #(.BLANK_CYCLES(20)) i_csr_setpoint_regs (.mclk, .rst_n, .wrReq, .rdAddr,
		.unlocked, .defaultSelectResistor(strap), .rdData, .rdHit, .buck3Set(b3Set),
		.bboostSet(bbSet), .buck3Blank(b3Blank), .bboostBlank(bbBlank));
	task cmpBit(input string n, input logic e, input logic s);
		checks++;
		if (s !== e)
		begin
			errors++;
			$display("MISMATCH %s expected %b seen %b", n, e, s);
		end
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge mclk);
		rdAddr = a;
		@(negedge mclk);
		checks++;
		if (rdData !== e)
		begin
			errors++;
			$display("MISMATCH rdData@%h expected %h seen %h", a, e, rdData);
		end
	endtask
	task results;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		#4000;
		errors++;
		results;
	end
	initial
	begin
		repeat (10) @(negedge mclk);
		rst_n = 1'b1;
		foreach (rows[i])
		begin
			i_csr_host_model.wr(rows[i][31:16], rows[i][32]);
			rd(rows[i][15:8], rows[i][7:0]);
			cmpBit("rdHit", rows[i][15:9] == CSR_ADDR_BUCK3[7:1], rdHit);
		end
		repeat (25) @(negedge mclk);
		i_csr_host_model.wr(16'h1881, 1'b1);
		cmpBit("b3Blank", 1'b1, b3Blank);
		cmpBit("bbBlank", 1'b0, bbBlank);
		cmpBit("b3Pse", 1'b1, b3Set.pulseSkipEnable);
		cmpBit("b3Code", 1'b1, b3Set.voltageCode == 6'h01);
		repeat (25) @(negedge mclk);
		cmpBit("b3Blank", 1'b0, b3Blank);
		strap = 1'b1;
		rst_n = 1'b0;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		rd(CSR_ADDR_BUCK3, CSR_ALT_BUCK3);
		rd(CSR_ADDR_BBOOST, CSR_ALT_BBOOST);
		cmpBit("bbPse", 1'b1, bbSet.pulseSkipEnable);
		cmpBit("b3Blank", 1'b0, b3Blank);
		results;
	end
endmodule
